// ==== logic/fpurg_top.sv ====
// power-up and reset gating sequencer of a serial flash device
// Operation
// - below write-inhibit supply, hold logic in reset, answer nothing
// - block write-type instructions until write-unlock delay has elapsed
// - reads served once select-after-supply delay elapsed after supply good and reset pin is high
// - power-up into standby; latch, busy flag and lock bits cleared
// - a reset low pulse clears every lock bit, except during the select-after-supply wait
// - reset during decode abandons instruction, returns to power-on state
// - reset during erase or program cycle aborts it to power-on state
// - reset during status write finishes it, then power-on state
// - reset while deselected in standby gives power-on state
// - delivered state reads erased bytes and zero status bits
`timescale 1ns/1ps
`default_nettype none
module fpurg_top
   import fpurg_pkg::*;
(
   input  wire logic CORE_CLK_I,
   input  wire logic RST_B_I,
   input  wire logic SUPPLY_ABOVE_INHIBIT_I,
   input  wire logic SUPPLY_GOOD_I,
   input  wire logic RESET_PIN_B_I,
   input  wire logic CHIP_SEL_B_I,
   input  wire logic DECODING_I,
   input  wire logic PROG_CYCLE_I,
   input  wire logic STATUS_WRITE_CYCLE_I,
   input  wire logic CMD_WRITE_TYPE_I,
   input  wire logic CMD_VALID_I,
   output logic      LOGIC_RESET_O,
   output logic      READ_ALLOW_O,
   output logic      WRITE_ALLOW_O,
   output logic      CMD_ACCEPT_O,
   output logic      CMD_ABORT_O,
   output logic      CYCLE_ABORT_O,
   output logic      CLEAR_LOCKS_O,
   output logic      CLEAR_WEL_WIP_O,
   output logic      DEEP_PD_CLEAR_O,
   output logic [7:0] STATUS_INIT_O,
   output logic [7:0] ERASED_BYTE_O
);
   typedef struct packed {
      fpurg_state_t state;
      logic         rst_pin_q;
      logic         logic_reset;
      logic         read_allow;
      logic         write_allow;
      logic         cmd_accept;
      logic         cmd_abort;
      logic         cycle_abort;
      logic         clear_locks;
      logic         clear_wel_wip;
      logic         hold_status;
      logic [7:0]   status_init;
      logic [7:0]   erased_byte;
   } fpurg_st_t;
   fpurg_st_t st_q;
   fpurg_st_t st_d;

   logic unlock_done;
   logic vsl_done;
   logic sw_done;
   logic reset_fall;

   // write-unlock delay counted from the inhibit threshold crossing
   fpurg_delay #(.COUNT(WRITE_UNLOCK_CYC)) u_unlock (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .run_i   (SUPPLY_ABOVE_INHIBIT_I),
      .done_o  (unlock_done)
   );

   // select-after-supply delay counted from supply good
   fpurg_delay #(.COUNT(SELECT_AFTER_SUPPLY_CYC)) u_vsl (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .run_i   (SUPPLY_GOOD_I & SUPPLY_ABOVE_INHIBIT_I),
      .done_o  (vsl_done)
   );

   // status-write time kept running while a status write is finished
   fpurg_delay #(.COUNT(STATUS_WRITE_CYC)) u_swt (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .run_i   (st_q.state == FPURG_HOLD_STATUS),
      .done_o  (sw_done)
   );

   // falling edge of the reset pin marks a reset pulse
   assign reset_fall = st_q.rst_pin_q & ~RESET_PIN_B_I;

   // next-state logic of the sequencer
   always_comb begin
      st_d               = st_q;
      st_d.rst_pin_q     = RESET_PIN_B_I;
      st_d.cmd_accept    = 1'b0;
      st_d.cmd_abort     = 1'b0;
      st_d.cycle_abort   = 1'b0;
      st_d.clear_locks   = 1'b0;
      st_d.clear_wel_wip = 1'b0;
      st_d.status_init   = STATUS_RESET_VAL;
      st_d.erased_byte   = ERASED_BYTE;
      unique case (st_q.state)
         FPURG_OFF: begin
            if (SUPPLY_ABOVE_INHIBIT_I) begin
               st_d.state = FPURG_WAIT_SUPPLY;
            end
         end
         FPURG_WAIT_SUPPLY: begin
            if (vsl_done && RESET_PIN_B_I) begin
               st_d.state = FPURG_READ_ONLY;
            end
         end
         FPURG_READ_ONLY: begin
            if (unlock_done) begin
               st_d.state = FPURG_RUN;
            end
         end
         FPURG_RUN: begin
         end
         FPURG_HOLD_STATUS: begin
            if (sw_done) begin
               st_d.state         = FPURG_RESET_MODE;
               st_d.clear_locks   = 1'b1;
               st_d.clear_wel_wip = 1'b1;
            end
         end
         FPURG_RESET_MODE: begin
            if (RESET_PIN_B_I) begin
               st_d.state = unlock_done ? FPURG_RUN : FPURG_READ_ONLY;
            end
         end
         default: begin
            st_d.state = FPURG_OFF;
         end
      endcase
      // reset pulse while powered: choose effect by activity
      if (reset_fall && st_q.state != FPURG_OFF
          && st_q.state != FPURG_WAIT_SUPPLY
          && st_q.state != FPURG_HOLD_STATUS) begin
         st_d.clear_locks = 1'b1;
         if (STATUS_WRITE_CYCLE_I) begin
            st_d.state = FPURG_HOLD_STATUS;
         end else begin
            st_d.state         = FPURG_RESET_MODE;
            st_d.clear_wel_wip = 1'b1;
            st_d.cmd_abort     = DECODING_I & ~CHIP_SEL_B_I;
            st_d.cycle_abort   = PROG_CYCLE_I;
         end
      end
      // supply below inhibit threshold overrides the next state, not the abort and accept pulses
      if (!SUPPLY_ABOVE_INHIBIT_I) begin
         st_d.state         = FPURG_OFF;
         st_d.clear_locks   = 1'b1;
         st_d.clear_wel_wip = 1'b1;
      end
      // gating of instructions follows the next state
      st_d.logic_reset = (st_d.state == FPURG_OFF)
                         || (st_d.state == FPURG_WAIT_SUPPLY)
                         || (st_d.state == FPURG_RESET_MODE);
      st_d.read_allow  = (st_d.state == FPURG_READ_ONLY)
                         || (st_d.state == FPURG_RUN);
      st_d.write_allow = (st_d.state == FPURG_RUN);
      st_d.hold_status = (st_d.state == FPURG_HOLD_STATUS);
      // accept a decoded instruction only when its class is allowed
      if (CMD_VALID_I && st_q.read_allow
          && (!CMD_WRITE_TYPE_I || st_q.write_allow)) begin
         st_d.cmd_accept = 1'b1;
      end
   end

   // state register; reset gives the power-on state
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         st_q               <= '0;
         st_q.state         <= FPURG_OFF;
         st_q.logic_reset   <= 1'b1;
         st_q.clear_locks   <= 1'b1;
         st_q.clear_wel_wip <= 1'b1;
         st_q.status_init   <= STATUS_RESET_VAL;
         st_q.erased_byte   <= ERASED_BYTE;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign LOGIC_RESET_O   = st_q.logic_reset;
   assign READ_ALLOW_O    = st_q.read_allow;
   assign WRITE_ALLOW_O   = st_q.write_allow;
   assign CMD_ACCEPT_O    = st_q.cmd_accept;
   assign CMD_ABORT_O     = st_q.cmd_abort;
   assign CYCLE_ABORT_O   = st_q.cycle_abort;
   assign CLEAR_LOCKS_O   = st_q.clear_locks;
   assign CLEAR_WEL_WIP_O = st_q.clear_wel_wip;
   // standby, never deep power-down, after any power-on state
   assign DEEP_PD_CLEAR_O = st_q.logic_reset;
   assign STATUS_INIT_O   = st_q.status_init;
   assign ERASED_BYTE_O   = st_q.erased_byte;

   // checks on the sequencer
   property p_inhibit_reset;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      !SUPPLY_ABOVE_INHIBIT_I |=> LOGIC_RESET_O && !READ_ALLOW_O;
   endproperty
   a_inhibit_reset: assert property (p_inhibit_reset)
      else $error("logic not held in reset below inhibit");

   property p_no_write_early;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      WRITE_ALLOW_O |-> unlock_done;
   endproperty
   a_no_write_early: assert property (p_no_write_early)
      else $error("writes allowed before unlock delay");

   property p_write_cmd_blocked;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CMD_VALID_I && CMD_WRITE_TYPE_I && !WRITE_ALLOW_O |=> !CMD_ACCEPT_O;
   endproperty
   a_write_cmd_blocked: assert property (p_write_cmd_blocked)
      else $error("write instruction accepted while locked");

   property p_read_after_vsl;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      READ_ALLOW_O |-> vsl_done || st_q.state == FPURG_RUN;
   endproperty
   a_read_after_vsl: assert property (p_read_after_vsl)
      else $error("reads allowed before select delay");

   property p_pulse_clears_locks;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      reset_fall && READ_ALLOW_O && !STATUS_WRITE_CYCLE_I
         && SUPPLY_ABOVE_INHIBIT_I
      |=> CLEAR_LOCKS_O && LOGIC_RESET_O;
   endproperty
   a_pulse_clears_locks: assert property (p_pulse_clears_locks)
      else $error("reset pulse did not clear locks");

   property p_decode_abort;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      reset_fall && READ_ALLOW_O && DECODING_I && !CHIP_SEL_B_I
         && !STATUS_WRITE_CYCLE_I && SUPPLY_ABOVE_INHIBIT_I
      |=> CMD_ABORT_O;
   endproperty
   a_decode_abort: assert property (p_decode_abort)
      else $error("decoding instruction not abandoned");

   property p_cycle_abort;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      reset_fall && READ_ALLOW_O && PROG_CYCLE_I
         && !STATUS_WRITE_CYCLE_I && SUPPLY_ABOVE_INHIBIT_I
      |=> CYCLE_ABORT_O;
   endproperty
   a_cycle_abort: assert property (p_cycle_abort)
      else $error("program cycle not aborted");

   property p_status_finish;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      reset_fall && READ_ALLOW_O && STATUS_WRITE_CYCLE_I
         && SUPPLY_ABOVE_INHIBIT_I
      |=> st_q.hold_status && !CYCLE_ABORT_O && !CLEAR_WEL_WIP_O;
   endproperty
   a_status_finish: assert property (p_status_finish)
      else $error("status write not allowed to finish");

   property p_off_clears_state;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      !SUPPLY_ABOVE_INHIBIT_I
      |=> CLEAR_LOCKS_O && CLEAR_WEL_WIP_O && DEEP_PD_CLEAR_O;
   endproperty
   a_off_clears_state: assert property (p_off_clears_state)
      else $error("power-on state not cleared below inhibit");

   property p_reset_mode_exit;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q.state == FPURG_RESET_MODE && RESET_PIN_B_I
         && SUPPLY_ABOVE_INHIBIT_I
      |=> READ_ALLOW_O && !LOGIC_RESET_O;
   endproperty
   a_reset_mode_exit: assert property (p_reset_mode_exit)
      else $error("reset mode not left after pin release");

   property p_status_hold_stays;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q.hold_status && !sw_done && SUPPLY_ABOVE_INHIBIT_I
      |=> st_q.hold_status && !LOGIC_RESET_O && !READ_ALLOW_O;
   endproperty
   a_status_hold_stays: assert property (p_status_hold_stays)
      else $error("status write hold left too early");

   property p_status_done;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q.hold_status && sw_done && SUPPLY_ABOVE_INHIBIT_I
      |=> CLEAR_LOCKS_O && CLEAR_WEL_WIP_O && LOGIC_RESET_O;
   endproperty
   a_status_done: assert property (p_status_done)
      else $error("no power-on state after status write time");

   property p_accept_needs_valid;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CMD_ACCEPT_O |-> $past(CMD_VALID_I) && $past(READ_ALLOW_O);
   endproperty
   a_accept_needs_valid: assert property (p_accept_needs_valid)
      else $error("instruction accepted without read permission");

   c_reach_run: cover property (@(posedge CORE_CLK_I)
      disable iff (!RST_B_I) $rose(WRITE_ALLOW_O));
   c_read_only: cover property (@(posedge CORE_CLK_I)
      disable iff (!RST_B_I) READ_ALLOW_O && !WRITE_ALLOW_O);
   c_hold_status: cover property (@(posedge CORE_CLK_I)
      disable iff (!RST_B_I) $fell(st_q.hold_status));
   c_cmd_abort: cover property (@(posedge CORE_CLK_I)
      disable iff (!RST_B_I) CMD_ABORT_O);
   c_cycle_abort: cover property (@(posedge CORE_CLK_I)
      disable iff (!RST_B_I) CYCLE_ABORT_O);
endmodule
`default_nettype wire

// ==== common/fpurg_pkg.sv ====
// package of constants and types for the flash power-up and reset gating block
package fpurg_pkg;
   // core clock rate
   localparam int unsigned CORE_CLK_HZ          = 25000000;
   // write-unlock delay: least 1 ms, longest 10 ms; least figure is used
   localparam int unsigned WRITE_UNLOCK_MIN_US  = 1000;
   localparam int unsigned WRITE_UNLOCK_MAX_US  = 10000;
   // select-after-supply delay, least 30 us
   localparam int unsigned SELECT_AFTER_SUPPLY_US = 30;
   // status-write time used to finish a status write under reset
   localparam int unsigned STATUS_WRITE_TIME_US = 15000;
   // least times round up to whole cycles
   localparam int unsigned WRITE_UNLOCK_CYC =
      (WRITE_UNLOCK_MIN_US * (CORE_CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned SELECT_AFTER_SUPPLY_CYC =
      (SELECT_AFTER_SUPPLY_US * (CORE_CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned STATUS_WRITE_CYC =
      (STATUS_WRITE_TIME_US * (CORE_CLK_HZ / 1000) + 999) / 1000;
   // counter width, enough for every count above
   localparam int unsigned CNT_W                = 20;
   // erased byte value and status reset value
   localparam logic [7:0]  ERASED_BYTE          = 8'hFF;
   localparam logic [7:0]  STATUS_RESET_VAL     = 8'h00;
   // sequencer states
   typedef enum logic [2:0] {
      FPURG_OFF,
      FPURG_WAIT_SUPPLY,
      FPURG_READ_ONLY,
      FPURG_RUN,
      FPURG_HOLD_STATUS,
      FPURG_RESET_MODE
   } fpurg_state_t;
endpackage

// ==== logic/fpurg_delay.sv ====
// one-shot delay counter: done rises a set number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module fpurg_delay
   import fpurg_pkg::*;
#(
   parameter int unsigned COUNT = 1
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_i,
   output var  logic done_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             done;
   } fpurg_dly_t;
   fpurg_dly_t st_q;
   fpurg_dly_t st_d;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

   // count while run is high, clear when it drops
   always_comb begin
      st_d = st_q;
      if (!run_i) begin
         st_d.cnt  = '0;
         st_d.done = 1'b0;
      end else if (!st_q.done) begin
         if (st_q.cnt == LAST) begin
            st_d.done = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign done_o = st_q.done;

   property p_done_after_count;
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(st_q.done) |-> $past(st_q.cnt) == LAST;
   endproperty
   a_done_after_count: assert property (p_done_after_count)
      else $error("delay finished at wrong count");
endmodule
`default_nettype wire

// ==== tb/fpurg_host_model.sv ====
// host controller model driving select, reset pin and decoded commands
`timescale 1ns/1ps
`default_nettype none
module fpurg_host_model #(
   parameter int RESET_TO_SELECT_CYC = 4
) (
   input  wire logic clk_i,
   output var  logic cs_b_o,
   output var  logic reset_b_o,
   output var  logic decoding_o,
   output var  logic valid_o,
   output var  logic write_type_o
);
   // idle: deselected, reset pin released
   initial begin
      cs_b_o       = 1'b1;
      reset_b_o    = 1'b1;
      decoding_o   = 1'b0;
      valid_o      = 1'b0;
      write_type_o = 1'b0;
   end
   // one decoded command with select low, write flag inverted after
   task automatic send(input logic wr);
      @(negedge clk_i);
      cs_b_o       = 1'b0;
      write_type_o = wr;
      valid_o      = 1'b1;
      @(negedge clk_i);
      valid_o      = 1'b0;
      cs_b_o       = 1'b1;
      write_type_o = ~wr;
   endtask
   // select and hold an instruction in decode
   task automatic select(input logic dec);
      @(negedge clk_i);
      cs_b_o     = 1'b0;
      decoding_o = dec;
   endtask
   // drop select once the instruction is over
   task automatic deselect();
      @(negedge clk_i);
      cs_b_o     = 1'b1;
      decoding_o = 1'b0;
   endtask
   // reset pin low, select untouched
   task automatic pin_low();
      @(negedge clk_i);
      reset_b_o = 1'b0;
   endtask
   // release the reset pin, then keep away before selecting
   task automatic pin_high();
      @(negedge clk_i);
      reset_b_o = 1'b1;
      repeat (RESET_TO_SELECT_CYC) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== tb/fpurg_top_tb.sv ====
// self-checking bench of the power-up and reset gating sequencer
`timescale 1ns/1ps
`default_nettype none
module fpurg_top_tb
   import fpurg_pkg::*;
;
   logic       clk = 0, rst_b = 0, above = 0, good = 0, prog = 0, sw = 0;
   wire logic  cs_b, pin_b, dec, valid, wr;
   logic       lrst, rd, wa, acc, cab, cyab, clr, clrw, dpd;
   logic [7:0] st, eb;
   int         bad_count = 0, checks = 0, cyc = 0, t0;
   int         n_acc, n_cab, n_cyab, n_clr;

   // 25 MHz clock and cycle count
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   fpurg_host_model host (.clk_i(clk), .cs_b_o(cs_b), .reset_b_o(pin_b),
      .decoding_o(dec), .valid_o(valid), .write_type_o(wr));

   fpurg_top DUT (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .SUPPLY_ABOVE_INHIBIT_I(above), .SUPPLY_GOOD_I(good),
      .RESET_PIN_B_I(pin_b), .CHIP_SEL_B_I(cs_b), .DECODING_I(dec),
      .PROG_CYCLE_I(prog), .STATUS_WRITE_CYCLE_I(sw),
      .CMD_WRITE_TYPE_I(wr), .CMD_VALID_I(valid), .LOGIC_RESET_O(lrst),
      .READ_ALLOW_O(rd), .WRITE_ALLOW_O(wa), .CMD_ACCEPT_O(acc),
      .CMD_ABORT_O(cab), .CYCLE_ABORT_O(cyab), .CLEAR_LOCKS_O(clr),
      .CLEAR_WEL_WIP_O(clrw), .DEEP_PD_CLEAR_O(dpd),
      .STATUS_INIT_O(st), .ERASED_BYTE_O(eb));

   // compare one value
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // count output pulses over n settled cycles
   task automatic watch(input int n);
      n_acc = 0; n_cab = 0; n_cyab = 0; n_clr = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         n_acc += (acc === 1'b1);
         n_cab += (cab === 1'b1);
         n_cyab += (cyab === 1'b1);
         n_clr += (clr === 1'b1);
      end
   endtask
   // power-up with pin high: delays, refusals and start state
   task automatic t_power_up;
      watch(2);
      chk(lrst, 1'b1);
      chk({clr, clrw, dpd, rd, wa}, 5'h1C);
      chk(st, 8'h00);
      chk(eb, 8'hFF);
      fork
         host.send(1'b0);
         watch(3);
      join
      chk(n_acc, 0);
      @(negedge clk);
      above = 1'b1;
      good = 1'b1;
      t0 = cyc;
      while (cyc - t0 < SELECT_AFTER_SUPPLY_CYC - 1) @(posedge clk);
      #1 chk(rd, 1'b0);
      repeat (4) @(posedge clk);
      #1 chk({rd, lrst, dpd, wa}, 4'h8);
      fork
         host.send(1'b1);
         watch(3);
      join
      chk(n_acc, 0);
      fork
         host.send(1'b0);
         watch(3);
      join
      chk(n_acc, 1);
      while (cyc - t0 < WRITE_UNLOCK_CYC - 2) @(posedge clk);
      #1 chk(wa, 1'b0);
      repeat (5) @(posedge clk);
      #1 chk(wa, 1'b1);
      fork
         host.send(1'b1);
         watch(3);
      join
      chk(n_acc, 1);
   endtask
   // pin pulses: deselected, mid-decode, mid-program
   task automatic t_pin_pulses;
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         prog = (k == 2);
         if (k == 1) host.select(1'b1);
         host.pin_low();
         watch(4);
         chk(n_clr != 0, 1'b1);
         chk(n_cab, k == 1);
         chk(n_cyab, k == 2);
         chk({lrst, wa}, 2'h2);
         host.deselect();
         prog = 1'b0;
         host.pin_high();
         watch(2);
         chk(wa, 1'b1);
      end
   endtask
   // pin low during status write: locks cleared, write kept, then supply loss
   task automatic t_status_hold;
      @(negedge clk);
      sw = 1'b1;
      host.pin_low();
      watch(40);
      chk(n_clr, 1);
      chk(n_cyab, 0);
      chk({lrst, rd, wa}, 3'h0);
      @(negedge clk);
      above = 1'b0;
      good = 1'b0;
      sw = 1'b0;
      watch(2);
      chk({lrst, clr, rd, wa}, 4'hC);
   endtask
   // second power-up with the pin held low past the select delay, then released
   task automatic t_pin_held_powerup;
      @(negedge clk);
      above = 1'b1;
      good = 1'b1;
      repeat (SELECT_AFTER_SUPPLY_CYC + 5) @(posedge clk);
      #1 chk(rd, 1'b0);
      host.pin_high();
      watch(2);
      chk(rd, 1'b1);
   endtask
   // report and end the run
   task automatic complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      t_power_up();
      t_pin_pulses();
      t_status_hold();
      t_pin_held_powerup();
      complete_run();
   end
   // watchdog, well past the write-unlock delay
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
